// >>> core/smsp_pkg.sv
package smsp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_GP_DIR = 7'h4C;
    localparam logic [6:0] IDX_GP_POL = 7'h4E;
    localparam logic [6:0] IDX_GP_PULL = 7'h50;
    localparam logic [6:0] IDX_GP_WMASK = 7'h52;
    localparam logic [6:0] IDX_GP_DATA = 7'h54;
    localparam logic [6:0] IDX_PWR_CLK = 7'h5C;
    localparam logic [6:0] IDX_PIN_ROLE = 7'h5E;
    localparam logic [6:0] IDX_GP_STICKY = 7'h60;

    // Field positions in the power and clock register
    localparam int unsigned PD_DEPTH_LSB = 0;
    localparam int unsigned CLK_EN_A_BIT = 4;
    localparam int unsigned CLK_EN_B_BIT = 5;
    localparam int unsigned XTAL_SEL_LSB = 8;

    // Field positions in the pin role register
    localparam int unsigned MIC_SEL_BIT = 0;
    localparam int unsigned WAKE_SEL_BIT = 1;
    localparam int unsigned MON_SEL_BIT = 2;
    localparam int unsigned MODE_LSB = 12;
    localparam int unsigned STRAP_DONE_BIT = 15;

    // Reset values
    localparam logic [7:0] GP_DIR_RST = 8'hFF;
    localparam logic [7:0] GP_PULL_RST = 8'hFF;
    localparam logic [7:0] GP_ZERO_RST = 8'h00;
    localparam logic [15:0] PWR_CLK_RST = 16'h0030;
    localparam logic [2:0] ROLE_RST = 3'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Serial interface modes; the position equals the codec identifier
    typedef enum logic [1:0] {
        SMSP_PRIMARY,
        SMSP_SEC_ID1,
        SMSP_SEC_ID2,
        SMSP_DSP
    } smsp_mode_t;

    // Strap levels {pin3, pin2} to mode
    function automatic smsp_mode_t strap_to_mode(input logic [1:0] s);
        return smsp_mode_t'(~s);
    endfunction

endpackage

// >>> core/smsp_top.sv
`timescale 1ns/1ns

module smsp_top
    import smsp_pkg::*;
#(
    parameter int unsigned ADDR_W = 9,
    parameter int unsigned BCLK_HALF = 4
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic pwrdn_n_pin,
    input wire logic crystal_in,
    output logic clk_out_pin,
    input wire logic bit_clk_i,
    output logic bit_clk_o,
    output logic bit_clk_oe,
    input wire logic sync_i,
    output logic sync_o,
    output logic sync_oe,
    output logic sdata_to_ctrl,
    input wire logic sdata_from_ctrl,
    input wire logic [7:0] gp_i,
    output logic [7:0] gp_o,
    output logic [7:0] gp_oe,
    output logic [7:0] gp_pull_en,
    // Core side
    output smsp_mode_t mode,
    output logic mode_valid,
    output logic [1:0] codec_id,
    output logic bclk_rise,
    output logic frame_sync,
    input wire logic frame_sync_req,
    input wire logic tx_bit,
    output logic rx_bit,
    input wire logic monitor_bit,
    output logic mic_path_en,
    output logic crystal_needed,
    output logic [1:0] crystal_freq_select,
    output logic powered_down,
    output logic [1:0] pd_depth
);

    // Two-flop synchronisers for all pin inputs
    logic [4:0] pin_s1_q, pin_s2_q;
    logic [7:0] gp_s1_q, gp_s2_q;
    logic pwr_s3_q, bclk_s3_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            gp_s1_q <= 8'hFF;
            gp_s2_q <= 8'hFF;
            pwr_s3_q <= 1'b0;
            bclk_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= {sdata_from_ctrl, sync_i, bit_clk_i, crystal_in, pwrdn_n_pin};
            pin_s2_q <= pin_s1_q;
            gp_s1_q <= gp_i;
            gp_s2_q <= gp_s1_q;
            pwr_s3_q <= pin_s2_q[0];
            bclk_s3_q <= pin_s2_q[2];
        end
    end

    logic pwr_n, xtal_s, pwr_rise;
    assign pwr_n = pin_s2_q[0];
    assign xtal_s = pin_s2_q[1];
    // Release of power-down; held low at power-up by the controller
    assign pwr_rise = pwr_n & ~pwr_s3_q;

    // Mode capture on core clock only, cleared solely by power-on reset
    logic strap_done_q;
    smsp_mode_t mode_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_done_q <= 1'b0;
            mode_q <= SMSP_PRIMARY;
        end else if (pwr_rise && !strap_done_q) begin
            strap_done_q <= 1'b1;
            mode_q <= strap_to_mode(gp_s2_q[3:2]);
        end
    end
    // Later straps and power cycles leave the mode alone

    logic clk_master;
    assign mode = mode_q;
    assign mode_valid = strap_done_q;
    assign codec_id = mode_q;
    assign clk_master = (mode_q == SMSP_PRIMARY) || (mode_q == SMSP_DSP);

    // Registers
    logic [7:0] dir_q, pol_q, pull_q, wmask_q, dout_q, sticky_q;
    logic [15:0] pwr_clk_q;
    logic [2:0] role_q;
    logic wake_hit, wake_q;
    logic [7:0] wake_bits;
    logic wr_hit, rd_hit;
    logic [2:0] wr_sel, rd_sel;

    // AXI write channel holding
    logic aw_got_q, w_got_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_wr;
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready = !w_got_q && !s_axi_bvalid;
    assign do_wr = aw_got_q && w_got_q;

    // Address decode: byte address must be an aligned register index
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a, output logic hit);
        logic [6:0] idx;
        idx = a[8:2];
        hit = (a[1:0] == 2'h0);
        reg_sel = 3'h0;
        unique case (idx)
            IDX_GP_DIR: reg_sel = 3'h0;
            IDX_GP_POL: reg_sel = 3'h1;
            IDX_GP_PULL: reg_sel = 3'h2;
            IDX_GP_WMASK: reg_sel = 3'h3;
            IDX_GP_DATA: reg_sel = 3'h4;
            IDX_PWR_CLK: reg_sel = 3'h5;
            IDX_PIN_ROLE: reg_sel = 3'h6;
            IDX_GP_STICKY: reg_sel = 3'h7;
            default: hit = 1'b0;
        endcase
    endfunction

    // Channel capture and write response
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Decode of the held write address and the offered read address
    always_comb begin
        wr_sel = reg_sel(awaddr_q, wr_hit);
        rd_sel = reg_sel(s_axi_araddr, rd_hit);
    end

    // Writable registers with byte lane strobes; general pins start as pulled-up inputs
    logic we;
    assign we = do_wr && wr_hit;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dir_q <= GP_DIR_RST;
            pull_q <= GP_PULL_RST;
            pol_q <= GP_ZERO_RST;
            wmask_q <= GP_ZERO_RST;
            dout_q <= GP_ZERO_RST;
            pwr_clk_q <= PWR_CLK_RST;
            role_q <= ROLE_RST;
        end else if (we) begin
            unique case (wr_sel)
                3'h0: if (wstrb_q[0]) dir_q <= wdata_q[7:0];
                3'h1: if (wstrb_q[0]) pol_q <= wdata_q[7:0];
                3'h2: if (wstrb_q[0]) pull_q <= wdata_q[7:0];
                3'h3: if (wstrb_q[0]) wmask_q <= wdata_q[7:0];
                3'h4: if (wstrb_q[0]) dout_q <= wdata_q[7:0];
                3'h5: begin
                    if (wstrb_q[0]) pwr_clk_q[7:0] <= wdata_q[7:0];
                    if (wstrb_q[1]) pwr_clk_q[15:8] <= wdata_q[15:8];
                end
                3'h6: if (wstrb_q[0]) role_q <= wdata_q[2:0];
                3'h7: ;
            endcase
        end
    end

    // Sticky wake flags: set wins over write-one-to-clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sticky_q <= GP_ZERO_RST;
        end else begin
            sticky_q <= (sticky_q & ~((we && wr_sel == 3'h7 && wstrb_q[0]) ? wdata_q[7:0] : 8'h00))
                        | wake_bits;
        end
    end

    // Read channel
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        unique case (rd_sel)
            3'h0: rd_val = {8'h00, dir_q};
            3'h1: rd_val = {8'h00, pol_q};
            3'h2: rd_val = {8'h00, pull_q};
            3'h3: rd_val = {8'h00, wmask_q};
            3'h4: rd_val = {8'h00, gp_s2_q};
            3'h5: rd_val = pwr_clk_q;
            3'h6: begin
                rd_val[2:0] = role_q;
                rd_val[MODE_LSB +: 2] = mode_q;
                rd_val[STRAP_DONE_BIT] = strap_done_q;
            end
            3'h7: rd_val = {8'h00, sticky_q};
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? {16'h0000, rd_val} : 32'h0000_0000;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Wake detection: masked pins at their selected level
    assign wake_bits = wmask_q & ~(gp_s2_q ^ pol_q);
    assign wake_hit = |wake_bits;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_hit;
        end
    end

    // General pin roles; strap pins stay passive inputs until the first release
    logic mic_sel, wake_sel, mon_sel;
    assign mic_sel = role_q[MIC_SEL_BIT];
    assign wake_sel = role_q[WAKE_SEL_BIT];
    assign mon_sel = role_q[MON_SEL_BIT];
    assign mic_path_en = mic_sel;
    always_comb begin
        gp_o = dout_q;
        gp_oe = ~dir_q;
        gp_pull_en = pull_q;
        gp_oe[1] = 1'b0;
        if (wake_sel) begin
            gp_o[3] = wake_q;
            gp_oe[3] = 1'b1;
        end
        if (mon_sel) begin
            gp_o[4] = monitor_bit;
            gp_oe[4] = 1'b1;
        end
        if (!strap_done_q) begin
            gp_oe[3:2] = 2'h0;
            gp_pull_en[3:2] = 2'h3;
        end
    end

    // Bit clock divider for the master modes
    logic [$clog2(BCLK_HALF+1)-1:0] bdiv_q;
    logic bclk_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bdiv_q <= '0;
            bclk_q <= 1'b0;
        end else if (strap_done_q && clk_master) begin
            if (bdiv_q == BCLK_HALF[$bits(bdiv_q)-1:0] - 1'b1) begin
                bdiv_q <= '0;
                bclk_q <= ~bclk_q;
            end else begin
                bdiv_q <= bdiv_q + 1'b1;
            end
        end
    end

    // Link pin directions follow the latched mode
    assign bit_clk_oe = strap_done_q && clk_master;
    assign bit_clk_o = bclk_q;
    assign sync_oe = strap_done_q && (mode_q == SMSP_DSP);
    assign bclk_rise = bit_clk_oe ? (bdiv_q == '0 && bclk_q) : (pin_s2_q[2] & ~bclk_s3_q);
    assign frame_sync = sync_oe ? sync_o : pin_s2_q[3];
    assign rx_bit = pin_s2_q[4];

    // Registered serial outputs
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_o <= 1'b0;
            sdata_to_ctrl <= 1'b0;
            clk_out_pin <= 1'b0;
        end else begin
            sync_o <= frame_sync_req && sync_oe;
            sdata_to_ctrl <= tx_bit;
            clk_out_pin <= xtal_s && pwr_clk_q[CLK_EN_A_BIT] && pwr_clk_q[CLK_EN_B_BIT];
        end
    end

    // Clocking and power status
    assign crystal_needed = clk_master || wake_sel;
    assign crystal_freq_select = pwr_clk_q[XTAL_SEL_LSB +: 2];
    assign powered_down = !pwr_n;
    assign pd_depth = pwr_clk_q[PD_DEPTH_LSB +: 2];

    // Checks
    a_mode_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
        pwr_rise && !strap_done_q |=> strap_done_q && mode_q == strap_to_mode($past(gp_s2_q[3:2])))
        else $error("strap mode not captured");
    a_mode_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
        strap_done_q |=> strap_done_q && $stable(mode_q))
        else $error("mode changed after capture");
    a_first_only: assert property (@(posedge core_clk) disable iff (sys_rst)
        !strap_done_q && !pwr_rise |=> !strap_done_q)
        else $error("capture without release");
    a_strap_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        !strap_done_q |-> gp_oe[3:2] == 2'h0 && gp_pull_en[3:2] == 2'h3)
        else $error("strap pins driven before capture");
    a_bclk_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
        strap_done_q |-> bit_clk_oe == (codec_id == 2'h0 || codec_id == 2'h3))
        else $error("bit clock direction wrong");
    a_sync_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
        sync_oe |-> strap_done_q && codec_id == 2'h3 && bit_clk_oe)
        else $error("sync direction wrong");
    a_wake_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
        strap_done_q && wake_sel && wake_hit ##1 wake_sel |-> gp_o[3] && gp_oe[3])
        else $error("wake output not raised");
    a_clk_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        !pwr_clk_q[CLK_EN_A_BIT] |=> !clk_out_pin)
        else $error("clock output not gated");
    a_mic_role: assert property (@(posedge core_clk) disable iff (sys_rst)
        mic_path_en |-> !gp_oe[1])
        else $error("mic pin driven");
    a_sdata_path: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> sdata_to_ctrl == $past(tx_bit))
        else $error("serial data not forwarded");
    a_gp_default: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> gp_oe == 8'h00 && gp_pull_en == 8'hFF)
        else $error("general pins not inputs after reset");

    c_dsp_mode: cover property (@(posedge core_clk) disable iff (sys_rst)
        pwr_rise && !strap_done_q ##1 mode_q == SMSP_DSP);
    c_secondary: cover property (@(posedge core_clk) disable iff (sys_rst)
        strap_done_q && mode_q == SMSP_SEC_ID2 && bclk_rise);
    c_second_release: cover property (@(posedge core_clk) disable iff (sys_rst)
        strap_done_q && pwr_rise);
    c_wake_out: cover property (@(posedge core_clk) disable iff (sys_rst)
        wake_sel && gp_o[3]);

endmodule

// >>> verification/smsp_ctrl_model.sv
`timescale 1ns/1ns

// Controller side of the link while the codec runs as a timing slave
module smsp_ctrl_model (
    input wire logic run,
    output logic bclk,
    output logic sync,
    output logic sdata
);
    logic [7:0] lfsr;
    int bitn;

    // Bit clock of 125 ns only while running, otherwise it stands still
    initial begin
        bclk = 1'b0;
        sync = 1'b0;
        sdata = 1'b0;
        lfsr = 8'hA5;
        bitn = 0;
        forever begin
            if (run === 1'b1) begin
                #62;
                bclk = 1'b1;
                // Frame sync and data change on the rising edge
                lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5]};
                sdata = lfsr[0];
                sync = (bitn % 16 == 0);
                bitn++;
                #63;
                bclk = 1'b0;
            end else begin
                // Idle lines keep moving so a stale value cannot pass
                #125;
                sdata = ~sdata;
                sync = ~sync;
            end
        end
    end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ns

module tb_top;
    import smsp_pkg::*;

    logic core_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [8:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, codec_id, crystal_freq_select, pd_depth;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic pwrdn_n_pin, crystal_in, clk_out_pin, bit_clk_i, bit_clk_o, bit_clk_oe;
    logic sync_i, sync_o, sync_oe, sdata_to_ctrl, sdata_from_ctrl;
    logic [7:0] gp_i, gp_o, gp_oe, gp_pull_en, gp_ext, gp_flt;
    smsp_mode_t mode;
    logic mode_valid, bclk_rise, frame_sync, frame_sync_req, tx_bit, rx_bit, monitor_bit;
    logic mic_path_en, crystal_needed, powered_down, ctl_bclk, ctl_sync, xtal_run;
    int n_errors = 0, checked = 0, seed = 71, cyc = 0, nrise = 0, nbo = 0;
    logic bo_q = 1'b0;

    // Pin levels seen by the codec: own drive, pull-up when floating, else the board
    assign gp_i = (gp_oe & gp_o) | (~gp_oe & gp_flt & gp_pull_en) | (~gp_oe & ~gp_flt & gp_ext);
    assign bit_clk_i = bit_clk_oe ? bit_clk_o : ctl_bclk;
    assign sync_i = sync_oe ? sync_o : ctl_sync;

    smsp_top #(.ADDR_W(9), .BCLK_HALF(4)) smsp_top_i (
        .core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pwrdn_n_pin, .crystal_in, .clk_out_pin, .bit_clk_i,
        .bit_clk_o, .bit_clk_oe, .sync_i, .sync_o, .sync_oe, .sdata_to_ctrl, .sdata_from_ctrl,
        .gp_i, .gp_o, .gp_oe, .gp_pull_en, .mode, .mode_valid, .codec_id, .bclk_rise,
        .frame_sync, .frame_sync_req, .tx_bit, .rx_bit, .monitor_bit, .mic_path_en,
        .crystal_needed, .crystal_freq_select, .powered_down, .pd_depth
    );

    smsp_ctrl_model smsp_ctrl_model_i (
        .run(~bit_clk_oe & mode_valid),
        .bclk(ctl_bclk),
        .sync(ctl_sync),
        .sdata(sdata_from_ctrl)
    );

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Cycle count, crystal stimulus, bit clock rise count and hang limit
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        crystal_in <= xtal_run & cyc[1];
        if (bclk_rise === 1'b1) nrise <= nrise + 1;
        bo_q <= bit_clk_o;
        if (bit_clk_o === 1'b1 && bo_q === 1'b0) nbo <= nbo + 1;
        if (cyc == 40000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [6:0] idx, input logic [15:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
    endtask

    task automatic rchk(input string what, input logic [6:0] idx, input logic [31:0] exp,
                        input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(what, exp, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask

    // Power-on with the strap pins held while power-down is low
    task automatic por(input logic [1:0] s, input logic flt);
        sys_rst <= 1'b1;
        pwrdn_n_pin <= 1'b0;
        gp_flt <= {4'h0, flt, flt, 2'b00};
        gp_ext <= {4'h0, s, 2'b00};
        tick(6);
        sys_rst <= 1'b0;
        tick(4);
        pwrdn_n_pin <= 1'b1;
        tick(6);
    endtask

    function automatic logic [1:0] exp_mode(input logic [1:0] s);
        return 2'd3 - s;
    endfunction

    initial begin
        logic [1:0] m;
        logic [31:0] v, d, e;
        logic [15:0] w;
        logic [7:0] oe;
        logic prev;
        int r0, ex, tg, b0;
        sys_rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 9'h000;
        s_axi_araddr = 9'h000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h3;
        {pwrdn_n_pin, frame_sync_req, tx_bit, monitor_bit, xtal_run} = 5'h00;
        gp_ext = 8'h00;
        gp_flt = 8'h00;
        crystal_in = 1'b0;
        // Every strap setting, first one left floating, crystal still
        for (int k = 0; k < 4; k++) begin
            por(2'(3 - k), k == 0);
            m = exp_mode(2'(3 - k));
            chk("gp_oe", 32'h0, gp_oe);
            chk("gp_pull_en", 32'hFF, gp_pull_en);
            chk("mode", 32'(m), 32'(mode));
            chk("codec_id", 32'(m), codec_id);
            chk("mode_valid", 1, mode_valid);
            chk("bit_clk_oe", m == 0 || m == 3, bit_clk_oe);
            chk("sync_oe", m == 3, sync_oe);
            chk("crystal_needed", m == 0 || m == 3, crystal_needed);
            rchk("role", IDX_PIN_ROLE, 32'h8000 | (32'(m) << 12), RESP_OKAY);
            r0 = nrise;
            b0 = nbo;
            ex = (m == 0 || m == 3) ? 20 : 13;
            tick(160);
            chk("bclk_rise", 1, (nrise - r0 >= ex - 1) && (nrise - r0 <= ex + 1));
            chk("bit_clk_o", 1, (m == 1 || m == 2) ? (nbo == b0) : (nbo - b0 >= 19 && nbo - b0 <= 21));
            if (m == 1 || m == 2) begin
                repeat (4) begin
                    @(posedge ctl_bclk);
                    tick(6);
                    chk("rx_bit", sdata_from_ctrl, rx_bit);
                    chk("frame_sync", ctl_sync, frame_sync);
                end
            end
            if (m == 3) begin
                frame_sync_req <= 1'b1;
                tick(3);
                chk("sync_o", 1, sync_o);
                chk("frame_sync", 1, frame_sync);
                frame_sync_req <= 1'b0;
            end
            v = $random(seed);
            tx_bit <= v[0];
            tick(3);
            chk("sdata_to_ctrl", v[0], sdata_to_ctrl);
        end
        rchk("dir", IDX_GP_DIR, 32'hFF, RESP_OKAY);
        rchk("pull", IDX_GP_PULL, 32'hFF, RESP_OKAY);
        rchk("pwr", IDX_PWR_CLK, 32'(PWR_CLK_RST), RESP_OKAY);
        rchk("unmapped", 7'h10, 32'h0, RESP_SLVERR);
        // Clock output enables, power-down depth and crystal select
        xtal_run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            w = {6'h00, v[9:8], 2'b00, 2'(i), 2'b00, v[1:0]};
            wr(IDX_PWR_CLK, w);
            tick(4);
            tg = 0;
            prev = clk_out_pin;
            repeat (40) begin
                tick(1);
                if (clk_out_pin !== prev) tg++;
                prev = clk_out_pin;
            end
            chk("clk_out", i == 3, tg > 4);
            chk("xtal_sel", 32'(v[9:8]), crystal_freq_select);
            chk("pd_depth", 32'(v[1:0]), pd_depth);
        end
        // Power-down cycle with changed straps keeps mode and registers
        gp_ext <= 8'h0C;
        pwrdn_n_pin <= 1'b0;
        tick(5);
        chk("powered_down", 1, powered_down);
        pwrdn_n_pin <= 1'b1;
        tick(6);
        chk("powered_down", 0, powered_down);
        chk("mode", 32'(SMSP_DSP), 32'(mode));
        rchk("pwr", IDX_PWR_CLK, 32'(w), RESP_OKAY);
        // General pins including the former strap pins
        repeat (3) begin
            d = $random(seed);
            v = $random(seed);
            e = $random(seed);
            // Pin 1 is input only, so it never takes a drive enable
            oe = ~d[7:0] & 8'hFD;
            gp_ext <= e[7:0];
            wr(IDX_GP_DIR, {8'h00, d[7:0]});
            wr(IDX_GP_DATA, {8'h00, v[7:0]});
            wr(IDX_GP_PULL, {8'h00, e[15:8]});
            tick(4);
            chk("gp_oe", 32'(oe), gp_oe);
            chk("gp_o", 32'(~d[7:0] & v[7:0]), gp_o & ~d[7:0]);
            chk("gp_pull_en", 32'(e[15:8]), gp_pull_en);
            rchk("pins", IDX_GP_DATA, 32'((oe & v[7:0]) | (~oe & e[7:0])), RESP_OKAY);
        end
        // Alternate pin roles
        wr(IDX_GP_DIR, 16'h00FF);
        wr(IDX_GP_WMASK, 16'h0001);
        wr(IDX_GP_POL, 16'h0001);
        gp_ext <= 8'h01;
        monitor_bit <= 1'b1;
        wr(IDX_PIN_ROLE, 16'h0007);
        tick(4);
        chk("mic_path_en", 1, mic_path_en);
        chk("gp_oe", 32'h3, gp_oe[4:3]);
        chk("wake", 1, gp_o[3]);
        chk("monitor", 1, gp_o[4]);
        monitor_bit <= 1'b0;
        tick(4);
        chk("monitor", 0, gp_o[4]);
        // Wake flag: the set wins over a clear while the level holds, then it clears
        wr(IDX_GP_STICKY, 16'h0001);
        rchk("sticky", IDX_GP_STICKY, 32'h01, RESP_OKAY);
        gp_ext <= 8'h00;
        tick(4);
        chk("wake", 0, gp_o[3]);
        wr(IDX_GP_STICKY, 16'h0001);
        rchk("sticky", IDX_GP_STICKY, 32'h00, RESP_OKAY);
        conclude();
    end
endmodule
